// File: pcw_pkg.sv
// Shared constants and types for the burst write width adapter.
// Assumes both ends run on the single PCI clock.
package pcw_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int AD_W = 64;
    localparam int BE_W = 8;
    localparam int BEATS_W = 8;

    // ----------------------------------------
    // Local status codes
    // ----------------------------------------
    localparam logic [3:0] STAT_IDLE = 4'h0;
    localparam logic [3:0] STAT_ADDR_LOAD = 4'h1;
    localparam logic [3:0] STAT_BUS_TRANS = 4'h2;
    localparam logic [3:0] STAT_BUS_TERM = 4'h3;

    // ----------------------------------------
    // Counts and reset values
    // ----------------------------------------
    localparam logic [7:0] BEATS_NARROW = 8'h04;
    localparam logic [7:0] BEATS_PENULT = 8'h02;
    localparam logic [7:0] BEATS_LAST = 8'h01;
    localparam logic [7:0] BEATS_RESET = 8'h00;
    localparam logic [63:0] AD_RESET = 64'h0000_0000_0000_0000;
    localparam logic [7:0] BE_RESET = 8'h00;
    localparam logic [31:0] ADDR_STEP_PAIR = 32'h0000_0008;
    localparam logic [31:0] ADDR_STEP_DWORD = 32'h0000_0004;

    // ----------------------------------------
    // Core state machine
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_REQ = 4'b0001,
        ST_GRANT = 4'b0010,
        ST_LOAD = 4'b0011,
        ST_ADDR = 4'b0100,
        ST_WAIT1 = 4'b0101,
        ST_WAIT2 = 4'b0110,
        ST_DATA = 4'b0111,
        ST_TURN = 4'b1000
    } pcw_state_t;

endpackage : pcw_pkg

// File: pcw_local_if.sv
// Local bus between the PCI master core and the local master.
// Assumes one clock; the testbench joins the two ends.
`timescale 1ns/10ps
interface pcw_local_if;
    logic local_wide_request_n;
    logic local_narrow_request_n;
    logic local_grant_n;
    logic [3:0] local_master_state_code;
    logic [pcw_pkg::BEATS_W-1:0] local_requested_beats;
    logic [pcw_pkg::AD_W-1:0] localAd;
    logic [pcw_pkg::BE_W-1:0] local_byte_lane_enables_in;
    logic local_side_ready_n;
    logic low_dword_taken_n;
    logic high_dword_taken_n;
    logic wide_transfer_flag_n;

    modport core (
        input local_wide_request_n,
        input local_narrow_request_n,
        output local_grant_n,
        output local_master_state_code,
        input local_requested_beats,
        input localAd,
        input local_byte_lane_enables_in,
        input local_side_ready_n,
        output low_dword_taken_n,
        output high_dword_taken_n,
        output wide_transfer_flag_n
    );

    modport lmaster (
        output local_wide_request_n,
        output local_narrow_request_n,
        input local_grant_n,
        input local_master_state_code,
        output local_requested_beats,
        output localAd,
        output local_byte_lane_enables_in,
        output local_side_ready_n,
        input low_dword_taken_n,
        input high_dword_taken_n,
        input wide_transfer_flag_n
    );
endinterface : pcw_local_if

// File: pcw_local_master.sv
// Local master end: issues one burst write request and feeds data pairs.
// Assumes the core end on the same clock behind pcw_local_if.
`timescale 1ns/10ps
module pcw_local_master (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Local bus
    pcw_local_if.lmaster lb,
    // User command
    input wire logic go,
    input wire logic [31:0] startAddr,
    input wire logic [3:0] busCmd,
    input wire logic [7:0] beats,
    // User data source
    input wire logic dataValid,
    input wire logic [63:0] dataIn,
    input wire logic [7:0] beIn,
    output logic dataTaken,
    output logic [31:0] addrCounter,
    output logic busy
);

    // ----------------------------------------
    // Request and address phase
    // ----------------------------------------
    logic reqN;
    logic inData;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reqN <= 1'b1;
            busy <= 1'b0;
        end else begin
            if (go && !busy) begin
                reqN <= 1'b0;
                busy <= 1'b1;
            end else if (lb.local_master_state_code == pcw_pkg::STAT_ADDR_LOAD) begin
                reqN <= 1'b1;
            end
            if (lb.local_master_state_code == pcw_pkg::STAT_BUS_TERM) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inData <= 1'b0;
        end else if (lb.local_master_state_code == pcw_pkg::STAT_ADDR_LOAD) begin
            inData <= 1'b1;
        end else if (lb.local_master_state_code == pcw_pkg::STAT_BUS_TERM) begin
            inData <= 1'b0;
        end
    end

    // ----------------------------------------
    // Address counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addrCounter <= 32'h0000_0000;
        end else if (go && !busy) begin
            addrCounter <= startAddr;
        end else if (!lb.low_dword_taken_n && !lb.high_dword_taken_n) begin
            addrCounter <= addrCounter + pcw_pkg::ADDR_STEP_PAIR;
        end else if (!lb.low_dword_taken_n || !lb.high_dword_taken_n) begin
            addrCounter <= addrCounter + pcw_pkg::ADDR_STEP_DWORD;
        end
    end

    // ----------------------------------------
    // Local bus drive
    // ----------------------------------------
    logic [31:0] latchedAddr;
    logic [3:0] latchedCmd;
    logic [7:0] latchedBeats;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latchedAddr <= 32'h0000_0000;
            latchedCmd <= 4'h0;
            latchedBeats <= pcw_pkg::BEATS_RESET;
        end else if (go && !busy) begin
            latchedAddr <= startAddr;
            latchedCmd <= busCmd;
            latchedBeats <= beats;
        end
    end

    // Pair is consumed once its high dword is taken
    assign dataTaken = inData && !lb.high_dword_taken_n;

    assign lb.local_wide_request_n = reqN;
    assign lb.local_narrow_request_n = 1'b1;
    assign lb.local_requested_beats = latchedBeats;
    assign lb.local_side_ready_n = !((inData || lb.local_master_state_code == pcw_pkg::STAT_ADDR_LOAD) && dataValid);
    // Data held until the core marks it taken
    assign lb.localAd = inData ? dataIn : {32'h0000_0000, latchedAddr};
    assign lb.local_byte_lane_enables_in = inData ? beIn : {4'h0, latchedCmd};

endmodule : pcw_local_master

// File: pcw_core.sv
// PCI master core end: burst write with fallback to a 32-bit target.
// Assumes PCI pins on the same clock; the testbench resolves wired pins.
// Notes on behaviour
// - Local master requests with address, command, length
// - Core raises reqn one clock after request
// - Grant plus idle bus starts, grants local
// - Address Loading status, latch address command length
// - Local master drops request after Address Loading
// - Address phase: framen, req64n, address, command
// - Burst counter loaded in address phase
// - First pair taken with both strobes
// - Local ready only when data available
// - Release reqn after framen without request
// - Narrow target asserts devseln, trdyn, not ack64n
// - First pair driven on full bus
// - Local master presents next pair
// - First data phase: irdyn high, strobes off
// - Untaken data held unchanged
// - One more clock to decide width
// - Narrow: clear wide flag, counter four, grant
// - No completion while irdyn deasserted
// - Counter decrements after each completed phase
// - Last phase deasserts framen and req64n
`timescale 1ns/10ps
module pcw_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Local bus
    pcw_local_if.core lb,
    // PCI arbitration
    output logic reqn,
    input wire logic gntn,
    // PCI control
    input wire logic framen_i,
    output logic framen_o,
    output logic framen_oe,
    input wire logic irdyn_i,
    output logic irdyn_o,
    output logic irdyn_oe,
    output logic req64n_o,
    output logic req64n_oe,
    input wire logic devseln,
    input wire logic trdyn,
    input wire logic ack64n,
    // PCI address and data
    output logic [63:0] ad_o,
    output logic adLow_oe,
    output logic adHigh_oe,
    output logic [7:0] cben_o,
    output logic cbenLow_oe,
    output logic cbenHigh_oe,
    // Status
    output logic [7:0] remaining_beat_counter
);

    // ----------------------------------------
    // State and latched request
    // ----------------------------------------
    pcw_pkg::pcw_state_t state;
    logic [31:0] addrLatch;
    logic [3:0] cmdLatch;
    logic [7:0] beatsLatch;
    logic phaseDone;
    logic busIdle;
    logic lastPhase;
    logic loadNow;
    logic startNow;
    logic pairTaken;

    // No completion while irdyn is not driven low
    assign phaseDone = irdyn_oe && !irdyn_o && !trdyn;
    assign busIdle = framen_i && irdyn_i;
    assign lastPhase = remaining_beat_counter == pcw_pkg::BEATS_LAST;
    assign loadNow = state == pcw_pkg::ST_GRANT && !gntn && !lb.local_wide_request_n;
    assign startNow = state == pcw_pkg::ST_LOAD && !gntn;
    assign pairTaken = !lb.low_dword_taken_n && !lb.high_dword_taken_n;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= pcw_pkg::ST_IDLE;
        end else begin
            case (state)
                pcw_pkg::ST_IDLE: begin
                    if (!lb.local_wide_request_n) begin
                        state <= pcw_pkg::ST_REQ;
                    end
                end
                pcw_pkg::ST_REQ: begin
                    if (!gntn && busIdle) begin
                        state <= pcw_pkg::ST_GRANT;
                    end
                end
                pcw_pkg::ST_GRANT: begin
                    if (loadNow) begin
                        state <= pcw_pkg::ST_LOAD;
                    end else if (gntn) begin
                        state <= pcw_pkg::ST_REQ;
                    end else begin
                        state <= pcw_pkg::ST_IDLE;
                    end
                end
                pcw_pkg::ST_LOAD: begin
                    if (startNow) begin
                        state <= pcw_pkg::ST_ADDR;
                    end else begin
                        state <= pcw_pkg::ST_REQ;
                    end
                end
                pcw_pkg::ST_ADDR: begin
                    if (pairTaken) begin
                        state <= pcw_pkg::ST_WAIT1;
                    end
                end
                pcw_pkg::ST_WAIT1: begin
                    state <= pcw_pkg::ST_WAIT2;
                end
                pcw_pkg::ST_WAIT2: begin
                    state <= pcw_pkg::ST_DATA;
                end
                pcw_pkg::ST_DATA: begin
                    if (phaseDone && lastPhase) begin
                        state <= pcw_pkg::ST_TURN;
                    end
                end
                pcw_pkg::ST_TURN: begin
                    state <= pcw_pkg::ST_IDLE;
                end
                default: begin
                    state <= pcw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Request latch and local status
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addrLatch <= 32'h0000_0000;
            cmdLatch <= 4'h0;
            beatsLatch <= pcw_pkg::BEATS_RESET;
        end else if (loadNow) begin
            addrLatch <= lb.localAd[31:0];
            cmdLatch <= lb.local_byte_lane_enables_in[3:0];
            beatsLatch <= lb.local_requested_beats;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lb.local_master_state_code <= pcw_pkg::STAT_IDLE;
        end else if (loadNow) begin
            lb.local_master_state_code <= pcw_pkg::STAT_ADDR_LOAD;
        end else if (startNow) begin
            lb.local_master_state_code <= pcw_pkg::STAT_BUS_TRANS;
        end else if (state == pcw_pkg::ST_LOAD) begin
            lb.local_master_state_code <= pcw_pkg::STAT_IDLE;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && lastPhase) begin
            lb.local_master_state_code <= pcw_pkg::STAT_BUS_TERM;
        end else if (state == pcw_pkg::ST_TURN) begin
            lb.local_master_state_code <= pcw_pkg::STAT_IDLE;
        end
    end

    // ----------------------------------------
    // Arbitration and local grant
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reqn <= 1'b1;
        end else if (state == pcw_pkg::ST_IDLE) begin
            reqn <= lb.local_wide_request_n;
        end else if (!framen_i && lb.local_wide_request_n) begin
            reqn <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lb.local_grant_n <= 1'b1;
        end else if (state == pcw_pkg::ST_REQ && !gntn && busIdle) begin
            lb.local_grant_n <= 1'b0;
        end else if (state == pcw_pkg::ST_WAIT1) begin
            lb.local_grant_n <= gntn;
        end else if (state == pcw_pkg::ST_TURN || (state == pcw_pkg::ST_LOAD && gntn)) begin
            lb.local_grant_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // Frame and width request
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            framen_o <= 1'b1;
            framen_oe <= 1'b0;
            req64n_o <= 1'b1;
            req64n_oe <= 1'b0;
        end else if (startNow) begin
            framen_o <= 1'b0;
            framen_oe <= 1'b1;
            req64n_o <= 1'b0;
            req64n_oe <= 1'b1;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && remaining_beat_counter == pcw_pkg::BEATS_PENULT) begin
            framen_o <= 1'b1;
            req64n_o <= 1'b1;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && lastPhase) begin
            framen_oe <= 1'b0;
            req64n_oe <= 1'b0;
        end
    end

    // Held high through both width-decision clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irdyn_o <= 1'b1;
            irdyn_oe <= 1'b0;
        end else if (state == pcw_pkg::ST_ADDR && pairTaken) begin
            irdyn_o <= 1'b1;
            irdyn_oe <= 1'b1;
        end else if (state == pcw_pkg::ST_WAIT2) begin
            irdyn_o <= 1'b0;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && lastPhase) begin
            irdyn_o <= 1'b1;
        end else if (state == pcw_pkg::ST_TURN) begin
            irdyn_oe <= 1'b0;
        end
    end

    // ----------------------------------------
    // Burst counter and width flag
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remaining_beat_counter <= pcw_pkg::BEATS_RESET;
        end else if (startNow) begin
            remaining_beat_counter <= beatsLatch;
        end else if (state == pcw_pkg::ST_WAIT1 && ack64n) begin
            remaining_beat_counter <= pcw_pkg::BEATS_NARROW;
        end else if (phaseDone && remaining_beat_counter != pcw_pkg::BEATS_RESET) begin
            remaining_beat_counter <= remaining_beat_counter - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lb.wide_transfer_flag_n <= 1'b1;
        end else if (startNow) begin
            lb.wide_transfer_flag_n <= 1'b0;
        end else if (state == pcw_pkg::ST_WAIT1 && ack64n) begin
            lb.wide_transfer_flag_n <= 1'b1;
        end else if (state == pcw_pkg::ST_TURN) begin
            lb.wide_transfer_flag_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // Local transfer strobes
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lb.low_dword_taken_n <= 1'b1;
            lb.high_dword_taken_n <= 1'b1;
        end else if (startNow || (state == pcw_pkg::ST_ADDR && !pairTaken)) begin
            lb.low_dword_taken_n <= lb.local_side_ready_n;
            lb.high_dword_taken_n <= lb.local_side_ready_n;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && !lastPhase && remaining_beat_counter[0]) begin
            lb.low_dword_taken_n <= 1'b0;
            lb.high_dword_taken_n <= 1'b1;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && !lastPhase
                && remaining_beat_counter != pcw_pkg::BEATS_NARROW) begin
            lb.low_dword_taken_n <= 1'b1;
            lb.high_dword_taken_n <= 1'b0;
        end else begin
            lb.low_dword_taken_n <= 1'b1;
            lb.high_dword_taken_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // Address and data lanes
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ad_o <= pcw_pkg::AD_RESET;
            cben_o <= pcw_pkg::BE_RESET;
            adLow_oe <= 1'b0;
            adHigh_oe <= 1'b0;
            cbenLow_oe <= 1'b0;
            cbenHigh_oe <= 1'b0;
        end else if (startNow) begin
            ad_o <= {32'h0000_0000, addrLatch};
            cben_o <= {4'h0, cmdLatch};
            adLow_oe <= 1'b1;
            cbenLow_oe <= 1'b1;
        end else if (state == pcw_pkg::ST_ADDR && pairTaken) begin
            ad_o <= lb.localAd;
            cben_o <= lb.local_byte_lane_enables_in;
            adHigh_oe <= 1'b1;
            cbenHigh_oe <= 1'b1;
        end else if (state == pcw_pkg::ST_WAIT1 && ack64n) begin
            adHigh_oe <= 1'b0;
            cbenHigh_oe <= 1'b0;
        end else if (state == pcw_pkg::ST_DATA && phaseDone && !lastPhase) begin
            if (remaining_beat_counter == pcw_pkg::BEATS_NARROW) begin
                ad_o[31:0] <= ad_o[63:32];
                cben_o[3:0] <= cben_o[7:4];
            end else if (remaining_beat_counter[0]) begin
                ad_o[31:0] <= lb.localAd[31:0];
                cben_o[3:0] <= lb.local_byte_lane_enables_in[3:0];
            end else begin
                ad_o[31:0] <= lb.localAd[63:32];
                cben_o[3:0] <= lb.local_byte_lane_enables_in[7:4];
            end
        end else if (state == pcw_pkg::ST_DATA && phaseDone) begin
            adLow_oe <= 1'b0;
            cbenLow_oe <= 1'b0;
        end
    end

endmodule : pcw_core

// File: pcw_checker.sv
// Checker: local bus and core pin timing of the burst write.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/10ps
module pcw_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Local bus
    input wire logic local_wide_request_n,
    input wire logic local_grant_n,
    input wire logic [3:0] local_master_state_code,
    input wire logic low_dword_taken_n,
    input wire logic high_dword_taken_n,
    input wire logic wide_transfer_flag_n,
    // PCI pins
    input wire logic reqn,
    input wire logic gntn,
    input wire logic framen_o,
    input wire logic framen_oe,
    input wire logic irdyn_o,
    input wire logic irdyn_oe,
    input wire logic req64n_o,
    input wire logic trdyn,
    input wire logic [7:0] remaining_beat_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    req_raise_a: assert property ($fell(local_wide_request_n) |-> ##[1:2] !reqn) else $error("no reqn");
    addr_load_a: assert property (local_master_state_code == pcw_pkg::STAT_ADDR_LOAD
        |-> !$past(gntn) && !$past(local_wide_request_n)) else $error("bad load");
    bus_trans_a: assert property ($past(local_master_state_code) == pcw_pkg::STAT_ADDR_LOAD && !$past(gntn)
        |-> local_master_state_code == pcw_pkg::STAT_BUS_TRANS && framen_oe && !framen_o && !req64n_o)
        else $error("bad address phase");
    strobe_hold_a: assert property (!low_dword_taken_n && !high_dword_taken_n
        |=> (low_dword_taken_n && high_dword_taken_n)[*2]) else $error("strobes");
    width_wait_a: assert property (!low_dword_taken_n && !high_dword_taken_n
        |=> ((!irdyn_oe || irdyn_o) && framen_oe && !framen_o)[*2]) else $error("width wait");
    narrow_set_a: assert property ($rose(wide_transfer_flag_n)
        |-> remaining_beat_counter == pcw_pkg::BEATS_NARROW && local_grant_n) else $error("narrow");
    reqn_drop_a: assert property (!$past(framen_o) && $past(framen_oe) && $past(local_wide_request_n)
        |-> reqn) else $error("reqn held");
    phase_dec_a: assert property (irdyn_oe && !irdyn_o && !trdyn
        |=> remaining_beat_counter == $past(remaining_beat_counter) - 8'h01) else $error("count");
endmodule : pcw_checker

// File: pci_master_burst_write_width_adapt_tb_top.sv
// Bench: both ends joined; the bench plays arbiter and 32-bit target.
// Assumes the package, interface and both ends compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errorCnt++; $display("[FAIL] %0t mismatch", $time); end end
module pci_master_burst_write_width_adapt_tb_top;
    localparam logic [63:0] DATA = 64'hB2B2_B2B2_A1A1_A1A1;
    logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, gntn = 1'b1, devseln = 1'b1, trdyn = 1'b1;
    logic [31:0] startAddr = 32'h0;
    logic [3:0] busCmd = 4'h0;
    logic reqn, framen_o, framen_oe, irdyn_o, irdyn_oe, req64n_o, req64n_oe, busy;
    logic adLow_oe, adHigh_oe, cbenLow_oe, cbenHigh_oe, framen_i, irdyn_i;
    logic [63:0] ad_o;
    logic [7:0] cben_o, remaining_beat_counter;
    int errorCnt = 0, nChecks = 0, cyc = 0;
    pcw_local_if lb();
    assign framen_i = framen_oe ? framen_o : 1'b1;
    assign irdyn_i = irdyn_oe ? irdyn_o : 1'b1;
    always #10 clk = ~clk;
    pcw_local_master pcw_local_master_inst (.clk, .rst_n, .lb(lb.lmaster), .go, .startAddr, .busCmd,
        .beats(8'h08), .dataValid(1'b1), .dataIn(DATA), .beIn(8'h00), .dataTaken(), .addrCounter(), .busy);
    pcw_core pcw_core_inst (.clk, .rst_n, .lb(lb.core), .reqn, .gntn, .framen_i, .framen_o, .framen_oe,
        .irdyn_i, .irdyn_o, .irdyn_oe, .req64n_o, .req64n_oe, .devseln, .trdyn, .ack64n(1'b1), .ad_o,
        .adLow_oe, .adHigh_oe, .cben_o, .cbenLow_oe, .cbenHigh_oe, .remaining_beat_counter);
    pcw_checker pcw_checker_inst (.clk, .rst_n, .local_wide_request_n(lb.local_wide_request_n),
        .local_grant_n(lb.local_grant_n), .local_master_state_code(lb.local_master_state_code),
        .low_dword_taken_n(lb.low_dword_taken_n), .high_dword_taken_n(lb.high_dword_taken_n),
        .wide_transfer_flag_n(lb.wide_transfer_flag_n), .reqn, .gntn, .framen_o, .framen_oe, .irdyn_o,
        .irdyn_oe, .req64n_o, .trdyn, .remaining_beat_counter);
    always @(negedge clk) begin
        gntn <= reqn | ~framen_i;
        devseln <= framen_i & (devseln | irdyn_i);
        trdyn <= framen_i & (devseln | irdyn_i);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errorCnt++;
            conclude();
        end
    end
    task conclude;
        $display("errors %0d checks %0d", errorCnt, nChecks);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // One burst to a narrow target, data words checked per phase
    task burst_write(input logic [31:0] addr, input logic [3:0] cmd);
        int k;
        int n;
        startAddr = addr;
        busCmd = cmd;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        k = 0;
        n = 0;
        while (!(framen_oe && !framen_o) && k < 50) begin
            @(negedge clk);
            k++;
        end
        `CHK(ad_o[31:0], addr)
        `CHK(cben_o[3:0], cmd)
        @(negedge clk);
        `CHK(remaining_beat_counter, 8'h08)
        while ((framen_oe || (irdyn_oe && !irdyn_o)) && k < 100) begin
            if (irdyn_oe && !irdyn_o && !trdyn) begin
                `CHK(ad_o[31:0], n[0] ? DATA[63:32] : DATA[31:0])
                `CHK(framen_i, 1'(n == 3))
                `CHK(adHigh_oe, 1'b0)
                n++;
            end
            @(negedge clk);
            k++;
        end
        `CHK(n, 4)
        repeat (4) @(negedge clk);
    endtask : burst_write
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        burst_write(32'h0000_1000, 4'h7);
        burst_write(32'h0000_2040, 4'hF);
        conclude();
    end
endmodule : pci_master_burst_write_width_adapt_tb_top
